// ===== pkg/hbs_pkg.sv
/*
  Constants, field layout and types shared by the bridge fault supervisor.
  Assumes a 10 MHz system clock and an AXI4-Lite register port.
*/
// Functional notes
// - Low-side current over limit for blanking interval: low off, high on, peak diagnostic bit.
// - Peak limit level is programmable; shutdown thresholds follow the programmed level.
// - Peak limiting sets only its diagnostic bit, no status flag, no lockout.
// - Low-side over shutdown longer than fault delay while blanking: lockout, short-to-supply.
// - High-side over shutdown longer than fault delay: lockout, short-to-ground bit.
// - Active high and low side both overcurrent: lockout, shorted-load bit.
// - Overtemperature shutdown indication: lockout, status flag, overtemperature bit.
// - Temperature limit region reduces peak limit and sets reduction bit and lower thermal region bit only.
// - Two thermal region bits readable; cleared by re-enable edge or diagnostic read.
// - Reduced peak limit stays latched until re-enable edge or diagnostic read.
// - Thermal reduction never touches the shutdown thresholds.
// - Open-load check only with switches off, entered through the enable pins.
// - Enable high, disable low: both bits set normal, both clear standby.
// - Open load when output one above and output two below reference.
// - Low-power pump bit; any limiting event forces high-power pump mode.
// - Supply or pump undervoltage floats outputs, unlatched, recovers automatically.
// - Logic-supply undervoltage: latched lockout, diagnostics and configuration lost.
// - Lockout left only by enable rise with disable low or disable fall.
// - Status flag pulled low on enable fall, released on rise, latched on faults.
// - Disable pin is an input unless status-flag mode bit is set.
package hbs_pkg;

  localparam int CLK_NS = 100;
  localparam int TB_NS  = 2000;
  localparam int TDF_NS = 1000;
  localparam int TA_NS  = 5000;
  localparam int TB_CYC_I  = (TB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TDF_CYC_I = (TDF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TA_CYC_I  = TA_NS / CLK_NS;

  typedef logic [7:0]  hbs_cnt_t;
  typedef logic [7:0]  hbs_addr_t;
  typedef logic [31:0] hbs_word_t;

  localparam hbs_cnt_t TB_CYC  = hbs_cnt_t'(TB_CYC_I);
  localparam hbs_cnt_t TDF_CYC = hbs_cnt_t'(TDF_CYC_I);
  localparam hbs_cnt_t TA_CYC  = hbs_cnt_t'(TA_CYC_I);
  localparam hbs_cnt_t CNT_ZERO = 8'h00;
  localparam hbs_cnt_t CNT_ONE  = 8'h01;

  localparam hbs_addr_t REG_CONFIG = 8'h00;
  localparam hbs_addr_t REG_DIAG   = 8'h04;
  localparam hbs_addr_t REG_STATUS = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CFG_LIM_LSB = 0;
  localparam int CFG_OE_LSB  = 2;
  localparam int CFG_SFM_BIT = 4;
  localparam int CFG_PMP_BIT = 5;
  localparam logic [7:0] CFG_RST = 8'h0C;

  localparam int DG_PEAK = 0;
  localparam int DG_TRED = 1;
  localparam int DG_OT   = 2;
  localparam int DG_SVS  = 3;
  localparam int DG_SGND = 4;
  localparam int DG_SLD  = 5;
  localparam int DG_OPEN = 6;

  localparam int SYNC_W = 15;

  typedef enum logic [2:0] {
    MD_STANDBY  = 3'h1,
    MD_OPENLOAD = 3'h2,
    MD_NORMAL   = 3'h4
  } hbs_mode_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_LOCK = 2'h2
  } hbs_state_t;

endpackage

// ===== pkg/hbs_sync_if.sv
/*
  Carrier between the supervisor and its input synchroniser.
  Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface hbs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// ===== hdl/hbs_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes raw inputs are asynchronous to i_clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_sync #(parameter int W = 1) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  hbs_sync_if.sync   sif
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] clean;
  } hbs_sst_t;

  hbs_sst_t q;
  hbs_sst_t d;

  always_comb begin
    d = q;
    d.f1 = sif.raw;
    d.f2 = q.f1;
    d.f3 = q.f2;
    // First stage feeds only the second; change counts once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (q.f2[i] == q.f3[i]) begin
        d.clean[i] = q.f3[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.clean = q.clean;
endmodule // hbs_sync
`default_nettype wire

// ===== hdl/hbs_supervisor.sv
/*
  Fault and mode supervisor of a four-switch motor bridge, with AXI4-Lite registers.
  Assumes analog comparators and pins are asynchronous; gate commands come
  from same-clock bridge logic.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module hbs_supervisor (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_awvalid,
  output logic                  o_awready,
  input  wire hbs_pkg::hbs_addr_t i_awaddr,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  input  wire hbs_pkg::hbs_word_t i_wdata,
  input  wire logic [3:0]       i_wstrb,
  output logic                  o_bvalid,
  input  wire logic             i_bready,
  output logic [1:0]            o_bresp,
  input  wire logic             i_arvalid,
  output logic                  o_arready,
  input  wire hbs_pkg::hbs_addr_t i_araddr,
  output logic                  o_rvalid,
  input  wire logic             i_rready,
  output hbs_pkg::hbs_word_t    o_rdata,
  output logic [1:0]            o_rresp,
  input  wire logic             i_en,
  input  wire logic             i_disable_or_status_pin,
  output logic                  o_disable_or_status_pin,
  output logic                  o_disable_or_status_pin_oe,
  input  wire logic [1:0]       i_ls_over_limit,
  input  wire logic [1:0]       i_ls_over_sd,
  input  wire logic [1:0]       i_hs_over_sd,
  input  wire logic             i_ot_sd,
  input  wire logic             i_t_limit,
  input  wire logic             i_uv_vs,
  input  wire logic             i_uv_pump,
  input  wire logic             i_uv_vcc,
  input  wire logic             i_out1_above_ref,
  input  wire logic             i_out2_above_ref,
  input  wire logic [1:0]       i_hs_cmd,
  input  wire logic [1:0]       i_ls_cmd,
  output logic [1:0]            o_hs_on,
  output logic [1:0]            o_ls_on,
  output logic [1:0]            o_limit_level,
  output logic [1:0]            o_sd_level,
  output logic                  o_pump_low_power,
  output logic                  o_open_load_en,
  output logic                  o_standby
);
  import hbs_pkg::*;

  typedef struct packed {
    hbs_state_t           fsm;
    logic [7:0]           cfg;
    logic [6:0]           diag;
    logic                 th_lo;
    logic                 th_hi;
    logic                 red;
    logic                 pump_force;
    logic                 sf_low;
    logic                 en_d;
    logic                 dis_d;
    logic [1:0][7:0]      blank;
    logic [1:0][7:0]      lsf;
    logic [1:0][7:0]      hsf;
    logic [1:0][7:0]      fw;
    logic [1:0]           hs_on;
    logic [1:0]           ls_on;
    logic [1:0]           lim;
    logic [1:0]           sdl;
    logic                 pump;
    logic                 olen;
    logic                 stby;
    logic                 aw_got;
    hbs_addr_t            aw_addr;
    logic                 w_got;
    hbs_word_t            w_data;
    logic                 w_strb0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    hbs_word_t            rdata;
    logic [1:0]           rresp;
  } hbs_st_t;

  localparam hbs_st_t ST_RST = '{fsm: ST_LOCK, cfg: CFG_RST, sf_low: 1'b1,
                                 stby: 1'b1, default: '0};

  hbs_st_t q;
  hbs_st_t d;

  hbs_sync_if #(.W(SYNC_W)) sif ();

  assign sif.raw = {i_en, i_disable_or_status_pin, i_ls_over_limit, i_ls_over_sd, i_hs_over_sd,
                    i_ot_sd, i_t_limit, i_uv_vs, i_uv_pump, i_uv_vcc,
                    i_out1_above_ref, i_out2_above_ref};

  hbs_sync #(.W(SYNC_W)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .sif       (sif)
  );

  logic       s_en;
  logic       s_dis;
  logic [1:0] s_ls_lim;
  logic [1:0] s_ls_sd;
  logic [1:0] s_hs_sd;
  logic       s_ot;
  logic       s_thermal_limit_point;
  logic       s_uv_vs;
  logic       s_uv_pump;
  logic       s_uv_vcc;
  logic       s_out1;
  logic       s_out2;

  assign {s_en, s_dis, s_ls_lim, s_ls_sd, s_hs_sd, s_ot, s_thermal_limit_point, s_uv_vs,
          s_uv_pump, s_uv_vcc, s_out1, s_out2} = sif.clean;

  logic      sfm;
  logic      dis_in;
  logic      en_rise;
  logic      en_fall;
  logic      reen;
  logic      uv_nl;
  logic      diag_rd;
  logic      clr;
  logic      run;
  logic      latch;
  logic      lim_any;
  hbs_mode_t mode;
  logic [1:0] oe_bits;
  logic [1:0] prog;
  logic [1:0] lim_ev;
  logic [1:0] f_svs;
  logic [1:0] f_sgnd;
  logic [1:0] f_sld;
  logic      aw_hs;
  logic      w_hs;
  logic      ar_hs;
  hbs_addr_t wa;
  hbs_word_t wd;
  logic      ws0;

  assign sfm     = q.cfg[CFG_SFM_BIT];
  assign dis_in  = sfm ? 1'b0 : s_dis;
  assign en_rise = s_en & ~q.en_d;
  assign en_fall = ~s_en & q.en_d;
  assign reen    = (en_rise & ~dis_in) | (~dis_in & q.dis_d & s_en);
  assign uv_nl   = s_uv_vs | s_uv_pump;
  assign oe_bits = q.cfg[CFG_OE_LSB +: 2];
  assign prog    = q.cfg[CFG_LIM_LSB +: 2];
  assign aw_hs   = i_awvalid & o_awready;
  assign w_hs    = i_wvalid & o_wready;
  assign ar_hs   = i_arvalid & o_arready;
  assign diag_rd = ar_hs & (i_araddr == REG_DIAG);
  assign clr     = reen | diag_rd;

  // Mixed output-enable bits with both enables active fall back to standby
  always_comb begin
    mode = MD_STANDBY;
    if (!s_en || dis_in) begin
      mode = (&oe_bits) ? MD_OPENLOAD : MD_STANDBY;
    end else if (&oe_bits) begin
      mode = MD_NORMAL;
    end
  end

  assign run = (mode == MD_NORMAL) & (q.fsm == ST_RUN) & ~uv_nl;

  always_comb begin
    d = q;
    lim_ev = '0;
    f_svs  = '0;
    f_sgnd = '0;
    f_sld  = '0;
    d.en_d  = s_en;
    d.dis_d = dis_in;

    for (int i = 0; i < 2; i++) begin
      if (q.fw[i] != CNT_ZERO) begin
        d.fw[i] = q.fw[i] - CNT_ONE;
      end
      if (run && i_ls_cmd[i] && s_ls_lim[i] && q.fw[i] == CNT_ZERO) begin
        d.blank[i] = q.blank[i] + CNT_ONE;
      end else begin
        d.blank[i] = CNT_ZERO;
      end
      if (q.blank[i] == TB_CYC) begin
        lim_ev[i]  = 1'b1;
        d.blank[i] = CNT_ZERO;
        d.fw[i]    = TA_CYC;
      end
      // Shutdown delay only counts inside the blanking window
      if (run && s_ls_sd[i] && q.blank[i] != CNT_ZERO) begin
        d.lsf[i] = q.lsf[i] + CNT_ONE;
      end else begin
        d.lsf[i] = CNT_ZERO;
      end
      f_svs[i] = (q.lsf[i] == TDF_CYC);
      if (run && s_hs_sd[i]) begin
        d.hsf[i] = q.hsf[i] + CNT_ONE;
      end else begin
        d.hsf[i] = CNT_ZERO;
      end
      f_sgnd[i] = (q.hsf[i] == TDF_CYC);
      f_sld[i] = run & i_hs_cmd[i] & s_hs_sd[i] & i_ls_cmd[1-i] & s_ls_lim[1-i];
    end

    lim_any = |lim_ev;
    latch = (|f_svs) | (|f_sgnd) | (|f_sld) | s_ot;

    // Set wins over clear for every sticky bit
    d.diag = clr ? '0 : q.diag;
    if (lim_any) d.diag[DG_PEAK] = 1'b1;
    if (s_thermal_limit_point && !s_ot) d.diag[DG_TRED] = 1'b1;
    if (s_ot) d.diag[DG_OT] = 1'b1;
    if (|f_svs) d.diag[DG_SVS] = 1'b1;
    if (|f_sgnd) d.diag[DG_SGND] = 1'b1;
    if (|f_sld) d.diag[DG_SLD] = 1'b1;
    if (mode == MD_OPENLOAD && s_out1 && !s_out2) begin
      d.diag[DG_OPEN] = 1'b1;
    end
    d.th_lo = (q.th_lo & ~clr) | s_thermal_limit_point;
    d.th_hi = (q.th_hi & ~clr) | s_ot;
    d.red   = (q.red & ~clr) | (s_thermal_limit_point & ~s_ot);

    unique case (q.fsm)
      ST_RUN: begin
        if (latch) d.fsm = ST_LOCK;
      end
      ST_LOCK: begin
        if (reen && !latch) d.fsm = ST_RUN;
      end
      default: d.fsm = ST_LOCK;
    endcase

    // Peak limiting alone never raises the flag
    if (latch) begin
      d.sf_low = 1'b1;
    end else if (en_rise) begin
      d.sf_low = 1'b0;
    end else if (en_fall) begin
      d.sf_low = 1'b1;
    end

    if (lim_any) d.pump_force = 1'b1;

    // Write path: address and data taken in either order
    wa  = aw_hs ? i_awaddr : q.aw_addr;
    wd  = w_hs ? i_wdata : q.w_data;
    ws0 = w_hs ? i_wstrb[0] : q.w_strb0;
    if (aw_hs) begin
      d.aw_got  = 1'b1;
      d.aw_addr = i_awaddr;
    end
    if (w_hs) begin
      d.w_got   = 1'b1;
      d.w_data  = i_wdata;
      d.w_strb0 = i_wstrb[0];
    end
    if (q.bvalid && i_bready) d.bvalid = 1'b0;
    if ((q.aw_got || aw_hs) && (q.w_got || w_hs)) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_SLVERR;
      if (wa == REG_CONFIG) begin
        d.bresp = RESP_OKAY;
        if (ws0) begin
          d.cfg = wd[7:0];
          d.pump_force = lim_any;
        end
      end
    end

    if (q.rvalid && i_rready) d.rvalid = 1'b0;
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      if (i_araddr == REG_CONFIG) begin
        d.rdata[7:0] = q.cfg;
      end else if (i_araddr == REG_DIAG) begin
        d.rdata[6:0] = q.diag;
      end else if (i_araddr == REG_STATUS) begin
        d.rdata[9:0] = {mode, uv_nl, q.pump, q.lim, q.th_hi, q.th_lo,
                        q.fsm == ST_LOCK};
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end

    // Logic-supply loss wipes everything the controller programmed
    if (s_uv_vcc) begin
      d.fsm    = ST_LOCK;
      d.cfg    = CFG_RST;
      d.diag   = '0;
      d.th_lo  = 1'b0;
      d.th_hi  = 1'b0;
      d.red    = 1'b0;
      d.sf_low = 1'b1;
      d.pump_force = 1'b0;
    end

    // Reduction narrows only the peak limit, one step down
    d.lim = (d.red && d.cfg[CFG_LIM_LSB +: 2] != 2'h0) ?
            d.cfg[CFG_LIM_LSB +: 2] - 2'h1 : d.cfg[CFG_LIM_LSB +: 2];
    d.sdl = d.cfg[CFG_LIM_LSB +: 2];
    d.pump = d.cfg[CFG_PMP_BIT] & ~d.pump_force;

    for (int i = 0; i < 2; i++) begin
      d.hs_on[i] = run & ~latch & ~s_uv_vcc & (i_hs_cmd[i] | (d.fw[i] != CNT_ZERO));
      d.ls_on[i] = run & ~latch & ~s_uv_vcc & i_ls_cmd[i] & (d.fw[i] == CNT_ZERO);
    end
    d.olen = (mode == MD_OPENLOAD);
    d.stby = (mode == MD_STANDBY);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign o_awready = ~q.aw_got & ~q.bvalid;
  assign o_wready  = ~q.w_got & ~q.bvalid;
  assign o_bvalid  = q.bvalid;
  assign o_bresp   = q.bresp;
  assign o_arready = ~q.rvalid;
  assign o_rvalid  = q.rvalid;
  assign o_rdata   = q.rdata;
  assign o_rresp   = q.rresp;

  assign o_disable_or_status_pin    = 1'b0;
  assign o_disable_or_status_pin_oe = sfm & (q.sf_low | uv_nl);
  assign o_hs_on          = q.hs_on;
  assign o_ls_on          = q.ls_on;
  assign o_limit_level    = q.lim;
  assign o_sd_level       = q.sdl;
  assign o_pump_low_power = q.pump;
  assign o_open_load_en   = q.olen;
  assign o_standby        = q.stby;
endmodule // hbs_supervisor
`default_nettype wire

// ===== verification/hbs_mcu_model.sv
/*
  Controller partner: drives the enable pin and the disable input.
  Assumes the bench asks for a wake or sleep right after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_mcu_model (
  input  wire logic i_clk_sys,
  input  wire logic i_wake,
  input  wire logic i_sleep,
  output logic      o_en,
  output logic      o_dis,
  output logic      o_busy
);
  int cnt;
  initial begin
    o_en = 1'b0;
    o_dis = 1'b0;
    o_busy = 1'b0;
    cnt = 0;
  end
  // Low phase outlasts the pin hold time, so the rise is seen as a fresh edge
  always @(posedge i_clk_sys) begin
    if (i_sleep) begin
      o_en <= 1'b0;
      o_dis <= 1'b1;
    end else if (i_wake && !o_busy) begin
      o_en <= 1'b0;
      o_dis <= 1'b0;
      o_busy <= 1'b1;
      cnt <= 25;
    end else if (o_busy) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_en <= 1'b1;
        o_busy <= 1'b0;
      end
    end
  end
endmodule // hbs_mcu_model
`default_nettype wire

// ===== verification/hbs_supervisor_sva.sv
/*
  Port-level checker for the bridge fault supervisor.
  Assumes it is bound to hbs_supervisor and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_supervisor_sva (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_wvalid,
  input wire logic       o_wready,
  input wire logic       i_en,
  input wire logic [1:0] i_ls_over_limit,
  input wire logic [1:0] i_hs_over_sd,
  input wire logic       i_ot_sd,
  input wire logic       i_t_limit,
  input wire logic       i_uv_vs,
  input wire logic       i_uv_vcc,
  input wire logic [1:0] i_ls_cmd,
  input wire logic [1:0] o_hs_on,
  input wire logic [1:0] o_ls_on,
  input wire logic [1:0] o_limit_level,
  input wire logic [1:0] o_sd_level,
  input wire logic       o_pump_low_power,
  input wire logic       o_standby
);
  logic [7:0] quiet_q;
  logic [7:0] hs_cnt_q;
  logic [7:0] lim_cnt_q;
  logic       off;
  assign off = (o_hs_on == 2'h0) && (o_ls_on == 2'h0);
  // Saturating counters; quiet also covers synchroniser delay after a supply loss
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_uv_vcc || (i_awvalid && o_awready) || (i_wvalid && o_wready)) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hFF) begin
      quiet_q <= quiet_q + 8'h01;
    end
    hs_cnt_q <= (i_rst || i_hs_over_sd == 2'h0) ? 8'h00 : hs_cnt_q + {7'h00, hs_cnt_q != 8'hFF};
    lim_cnt_q <= (i_rst || !(i_ls_over_limit[0] && i_ls_cmd[0])) ? 8'h00
                 : lim_cnt_q + {7'h00, lim_cnt_q != 8'hFF};
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_ot_held;  i_ot_sd [*8];  endsequence
  sequence s_vs_low;   i_uv_vs [*8];  endsequence
  sequence s_vcc_low;  i_uv_vcc [*8]; endsequence
  sequence s_en_off;   !i_en [*8];    endsequence
  sequence s_hot;      i_t_limit [*8]; endsequence
  reset_state_a: assert property ($fell(i_rst) |-> off && o_standby)
    else $error("switch outputs not cleared after reset");
  ot_lock_a: assert property (s_ot_held |-> off)
    else $error("switch on during overtemperature");
  uv_vs_off_a: assert property (s_vs_low |-> off)
    else $error("switch on during supply undervoltage");
  uv_vcc_off_a: assert property (s_vcc_low |=> off)
    else $error("switch on during logic undervoltage");
  en_low_off_a: assert property (s_en_off |-> off)
    else $error("switch on with enable low");
  hs_short_a: assert property (hs_cnt_q == 8'd24 |-> off)
    else $error("no lockout on high-side short");
  sd_steady_a: assert property (quiet_q > 8'd8 |-> $stable(o_sd_level))
    else $error("shutdown level moved without a write");
  limit_reduce_a: assert property (s_hot |->
      o_limit_level == ((o_sd_level == 2'h0) ? 2'h0 : o_sd_level - 2'h1))
    else $error("peak limit not reduced in limit region");
  peak_limit_a: assert property (lim_cnt_q == 8'd30 && $past(o_ls_on[0], 25) |->
      !o_ls_on[0] && o_hs_on[0] && !o_pump_low_power)
    else $error("peak limit action missing");
endmodule // hbs_supervisor_sva
bind hbs_supervisor hbs_supervisor_sva chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .i_en(i_en), .i_ls_over_limit(i_ls_over_limit), .i_hs_over_sd(i_hs_over_sd),
  .i_ot_sd(i_ot_sd), .i_t_limit(i_t_limit), .i_uv_vs(i_uv_vs), .i_uv_vcc(i_uv_vcc),
  .i_ls_cmd(i_ls_cmd), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_limit_level(o_limit_level),
  .o_sd_level(o_sd_level), .o_pump_low_power(o_pump_low_power), .o_standby(o_standby));
`default_nettype wire

// ===== verification/hbs_supervisor_bench.sv
/*
  Self-checking bench for the bridge fault supervisor.
  Assumes the controller model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_supervisor_bench;
  import hbs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic thermal_limit_point = 1'b0, o1 = 1'b0, o2 = 1'b0, wake = 1'b0, sleep = 1'b0;
  logic awr, wrd, bv, arr, rv, en, dis_m, busy, sf_oe, sfo, dis_pin, pump, ol, stby;
  logic [1:0] lim_ov = 2'h0, hs_c = 2'h0, ls_c = 2'h0, uvs = 2'h0;
  logic [1:0] br, rr, hs_on, ls_on, lvl, sdl, rsp;
  logic [3:0] flt = 4'h0;
  hbs_addr_t aw_a = 8'h00, ar_a = 8'h00;
  hbs_word_t w_d = 32'h0, rdat, dat;
  logic [31:0] seed = 32'hCBE6C37D;
  int failures = 0, total_checks = 0, cyc = 0, m_cfg, m_diag, lim;
  always #50 clk = ~clk;
  // Pin is open drain in flag mode, with a pull-up behind the controller
  assign dis_pin = sf_oe ? sfo : dis_m;
  hbs_supervisor uut (.i_clk_sys(clk), .i_rst(rst), .i_awvalid(aw_v), .o_awready(awr),
    .i_awaddr(aw_a), .i_wvalid(w_v), .o_wready(wrd), .i_wdata(w_d), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(b_r), .o_bresp(br), .i_arvalid(ar_v), .o_arready(arr),
    .i_araddr(ar_a), .o_rvalid(rv), .i_rready(r_r), .o_rdata(rdat), .o_rresp(rr),
    .i_en(en), .i_disable_or_status_pin(dis_pin), .o_disable_or_status_pin(sfo), .o_disable_or_status_pin_oe(sf_oe),
    .i_ls_over_limit(lim_ov | {flt[3], 1'b0}), .i_ls_over_sd({flt[3], 1'b0}),
    .i_hs_over_sd({1'b0, flt[1]}), .i_ot_sd(flt[0]), .i_t_limit(thermal_limit_point), .i_uv_vs(uvs[0]),
    .i_uv_pump(uvs[1]), .i_uv_vcc(flt[2]), .i_out1_above_ref(o1), .i_out2_above_ref(o2),
    .i_hs_cmd(hs_c), .i_ls_cmd(ls_c | {flt[3], 1'b0}),
    .o_hs_on(hs_on), .o_ls_on(ls_on), .o_limit_level(lvl), .o_sd_level(sdl),
    .o_pump_low_power(pump), .o_open_load_en(ol), .o_standby(stby));
  hbs_mcu_model mcu (.i_clk_sys(clk), .i_wake(wake), .i_sleep(sleep), .o_en(en),
    .o_dis(dis_m), .o_busy(busy));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input hbs_addr_t a, input hbs_word_t d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    aw_v <= 1'b1; w_v <= 1'b1; aw_a <= a; w_d <= d; b_r <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (aw_v && awr) ta = 1'b1;
      if (w_v && wrd) tw = 1'b1;
      aw_v <= !ta;
      w_v <= !tw;
    end
    do @(posedge clk); while (!bv);
    rsp = br;
  endtask
  task automatic rc(input hbs_addr_t a, input hbs_word_t m, input hbs_word_t e,
                    input logic [1:0] er);
    ar_v <= 1'b1; ar_a <= a; r_r <= 1'b1;
    do @(posedge clk); while (!arr);
    ar_v <= 1'b0;
    do @(posedge clk); while (!rv);
    dat = rdat;
    chk(dat & m, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask
  task automatic cfg_wr();
    wr(REG_CONFIG, m_cfg);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rc(REG_CONFIG, 32'h3F, m_cfg, RESP_OKAY);
  endtask
  task automatic reen();
    wake <= 1'b1;
    repeat (2) @(posedge clk);
    wake <= 1'b0;
    while (busy) @(posedge clk);
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    m_cfg = 32'h0C;
    m_diag = 0;
    rc(REG_CONFIG, 32'h3F, m_cfg, RESP_OKAY);
    rc(REG_DIAG, 32'h7F, m_diag, RESP_OKAY);
    rc(8'h0C, 32'h0, 32'h0, RESP_SLVERR);
    wr(REG_DIAG, 32'hFF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    lim = 1 + int'(rnd() % 32'd3);
    m_cfg = 32'h2C | lim;
    cfg_wr();
    reen();
    chk({30'h0, sdl}, lim);
    rc(REG_STATUS, 32'h381, 32'h200, RESP_OKAY);
    hs_c <= 2'h3;
    repeat (2) @(posedge clk);
    chk({30'h0, hs_on}, 32'h3);
    hs_c <= 2'h0; ls_c <= 2'h1;
    repeat (3) @(posedge clk);
    lim_ov <= 2'h1;
    repeat (30) @(posedge clk);
    chk({hs_on[0], ls_on[0], pump}, 3'b100);
    lim_ov <= 2'h0; ls_c <= 2'h0;
    repeat (60) @(posedge clk);
    rc(REG_DIAG, 32'h7F, 32'h01, RESP_OKAY);
    rc(REG_STATUS, 32'h21, 32'h0, RESP_OKAY);
    thermal_limit_point <= 1'b1;
    repeat (12) @(posedge clk);
    thermal_limit_point <= 1'b0;
    repeat (12) @(posedge clk);
    chk({lvl, sdl}, {lim[1:0] - 2'h1, lim[1:0]});
    rc(REG_STATUS, 32'h02, 32'h02, RESP_OKAY);
    rc(REG_DIAG, 32'h7F, 32'h02, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({30'h0, lvl}, lim);
    rc(REG_STATUS, 32'h06, 32'h0, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      hs_c <= 2'h1;
      flt <= 4'h1 << k;
      repeat (30) @(posedge clk);
      chk({hs_on, ls_on}, 4'h0);
      flt <= 4'h0;
      repeat (10) @(posedge clk);
      chk({30'h0, hs_on}, 32'h0);
      m_diag = (k == 0) ? 32'h04 : (k == 1) ? 32'h10 : (k == 3) ? 32'h08 : 32'h0;
      rc(REG_DIAG, 32'h7F, m_diag, RESP_OKAY);
      if (k == 2) begin
        rc(REG_CONFIG, 32'h3F, 32'h0C, RESP_OKAY);
        m_cfg = 32'h0C | lim;
        cfg_wr();
      end
      reen();
      chk({30'h0, hs_on}, 32'h1);
    end
    m_cfg = 32'h1C | lim;
    cfg_wr();
    // Supply, pump and both together; flag follows the undervoltage
    for (int j = 1; j < 4; j++) begin
      uvs <= 2'(j);
      repeat (12) @(posedge clk);
      chk({sf_oe, hs_on}, 3'b100);
      uvs <= 2'h0;
      repeat (12) @(posedge clk);
      chk({sf_oe, hs_on}, 3'b001);
    end
    hs_c <= 2'h0; sleep <= 1'b1; o1 <= 1'b1; o2 <= 1'b0;
    repeat (12) @(posedge clk);
    chk({sf_oe, sfo, ol, hs_on}, 5'b10100);
    rc(REG_DIAG, 32'h40, 32'h40, RESP_OKAY);
    o2 <= 1'b1;
    repeat (8) @(posedge clk);
    // Open-load bit is sticky: first read still reports it and clears it
    rc(REG_DIAG, 32'h40, 32'h40, RESP_OKAY);
    rc(REG_DIAG, 32'h40, 32'h0, RESP_OKAY);
    m_cfg = lim;
    cfg_wr();
    repeat (3) @(posedge clk);
    chk({stby, ol, sf_oe}, 3'b100);
    final_report();
  end
endmodule // hbs_supervisor_bench
`default_nettype wire
